// ### src/tmoc_regs.vh
// Register offsets, field positions and reset values of the timer mode/output control
`ifndef TMOC_REGS_VH
`define TMOC_REGS_VH
// Mode control register
`define TMOC_MODE_ADDR      16'hFF48
`define TMOC_MODE_RESET     8'h00
`define TMOC_MODE_OVF_BIT   0
`define TMOC_MODE_LO_BIT    1
`define TMOC_MODE_MID_BIT   2
`define TMOC_MODE_HI_BIT    3
// Clock select register
`define TMOC_CLK_ADDR       16'hFF40
`define TMOC_CLK_RESET      8'h00
`define TMOC_CLK_CLOCK_OUT_ENABLE_BIT   7
// Output control register
`define TMOC_OUT_ADDR       16'hFF4E
`define TMOC_OUT_RESET      8'h00
`define TMOC_OUT_OE_BIT     0
`define TMOC_OUT_LVL_BIT    1
`define TMOC_OUT_INV_BIT    2
`define TMOC_OUT_RST_BIT    4
`define TMOC_OUT_SET_BIT    5
`define TMOC_OUT_WMASK      8'h37
// Compare, count and capture registers, 16-bit access
`define TMOC_CMP_ADDR       16'hFF10
`define TMOC_CNT_ADDR       16'hFF12
`define TMOC_CAP_ADDR       16'hFF14
`endif

// ### src/tmoc_pwm.v
// Fourteen-bit PWM generator with active level selection
`include "tmoc_regs.vh"
module tmoc_pwm #(
    parameter WIDTH = 14
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             reset_n,
    // Control
    input  wire             enable,
    input  wire             tick,
    input  wire [WIDTH-1:0] duty,
    input  wire             active_high,
    // Output
    output reg              pwm_out
);
    reg [WIDTH-1:0] phase_reg;   // Free-running phase counter

    // Phase advances on each count tick; duty compared each cycle
    always @(posedge mclk) begin
        if (!reset_n || !enable) begin
            phase_reg <= {WIDTH{1'b0}};
            pwm_out   <= 1'b0;
        end else begin
            if (tick)
                phase_reg <= phase_reg + 1'b1;
            // Active while phase below duty, polarity set by level bit
            pwm_out <= (phase_reg < duty) ? active_high : ~active_high;
        end
    end
endmodule

// ### src/tmoc_top.v
// Sixteen-bit timer with mode control, output control and clock-out enable
`include "tmoc_regs.vh"
// Functional notes
// - Reset clears mode register, timer stopped
// - Nonzero mode runs; zero stops and clears
// - Decode stop, PWM, free, edge, match
// - Overflow flag on wrap from all ones
// - Clock-out enable gates the clock pin
// - Reset clears output control register
// - Output control: set, reset, level, invert, enable
// - Set/reset bits act at write, read zero
// - Compare continuously while running, match raises request
module tmoc_top (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // CPU register port
    input  wire [15:0] cpu_addr,
    input  wire        cpu_wr,
    input  wire        cpu_rd,
    input  wire        cpu_bit_op,
    input  wire [7:0]  cpu_bit_mask,
    input  wire [15:0] cpu_wdata,
    output reg  [15:0] cpu_rdata,
    // Timer events
    input  wire        count_tick,
    input  wire        input_edge,
    input  wire        clock_out_src,
    // Pins and requests
    output wire        timer_output_pin,
    output wire        programmable_clock_pin,
    output wire        compare_match_irq,
    output wire [15:0] count_register_value
);
    // Mode states, one-hot
    // Decoded view of the mode field; no stored state of its own
    localparam [4:0] ST_STOP  = 5'h01;
    localparam [4:0] ST_PWM   = 5'h02;
    localparam [4:0] ST_FREE  = 5'h04;
    localparam [4:0] ST_EDGE  = 5'h08;
    localparam [4:0] ST_MATCH = 5'h10;

    reg  [7:0]  timer_mode_ctrl_reg;      // Mode and overflow
    reg  [7:0]  count_clock_select_reg;   // Clock select with clock-out enable
    reg  [7:0]  timer_output_ctrl_reg;    // Output control, set/reset held zero
    reg  [15:0] compare_register_reg;     // Compare value
    reg  [15:0] count_register_reg;       // Running count
    reg  [15:0] capture_register_reg;     // Captured count
    reg         output_flipflop_reg;      // R-S output flip-flop
    reg         match_irq_reg;            // Registered compare request
    reg  [7:0]  mode_next;
    reg  [7:0]  clk_next;
    reg  [7:0]  out_next;
    reg  [4:0]  state;
    wire        pwm_wave;

    // Merge byte or single-bit write into an old value
    function [7:0] merge8;
        input [7:0] old_v;
        input [7:0] new_v;
        input       bit_op;
        input [7:0] mask;
        begin
            if (bit_op)
                merge8 = (old_v & ~mask) | (new_v & mask);
            else
                merge8 = new_v;
        end
    endfunction

    // Address decode of the register port
    wire wr_mode = cpu_wr && (cpu_addr == `TMOC_MODE_ADDR);
    wire wr_clk  = cpu_wr && (cpu_addr == `TMOC_CLK_ADDR);
    wire wr_out  = cpu_wr && (cpu_addr == `TMOC_OUT_ADDR);
    wire wr_cmp  = cpu_wr && (cpu_addr == `TMOC_CMP_ADDR);
    wire rd_cap  = cpu_rd && (cpu_addr == `TMOC_CAP_ADDR);

    // Mode field views and count events
    wire [2:0] mode_field = timer_mode_ctrl_reg[`TMOC_MODE_HI_BIT:`TMOC_MODE_LO_BIT];
    wire       running    = (mode_field != 3'b000);
    wire       edge_tog   = timer_mode_ctrl_reg[`TMOC_MODE_LO_BIT];
    wire       match      = running && (count_register_reg == compare_register_reg);
    // An edge clear in edge mode is not a wrap, even at all ones
    wire       wrap       = running && count_tick && (count_register_reg == 16'hFFFF) &&
                            !(state == ST_EDGE && input_edge);
    // Match is a level while the count idles between ticks; toggling on it
    // would chatter, so the flip-flop acts on the first cycle of a match only
    wire       match_rise = match && !match_irq_reg;

    // Mode decode of bits 3..1
    always @* begin
        case (mode_field)
            3'b000:         state = ST_STOP;
            3'b001:         state = ST_PWM;
            3'b010, 3'b011: state = ST_FREE;
            3'b100, 3'b101: state = ST_EDGE;
            3'b110, 3'b111: state = ST_MATCH;
            default:        state = ST_STOP;
        endcase
    end

    // Next-value merge for the byte registers
    always @* begin
        mode_next = merge8(timer_mode_ctrl_reg, cpu_wdata[7:0], cpu_bit_op, cpu_bit_mask);
        clk_next  = merge8(count_clock_select_reg, cpu_wdata[7:0], cpu_bit_op, cpu_bit_mask);
        out_next  = merge8(timer_output_ctrl_reg, cpu_wdata[7:0], cpu_bit_op, cpu_bit_mask);
    end

    // Register writes and overflow flag
    // Writes while running are taken as given; software stops first
    always @(posedge mclk) begin
        if (!reset_n) begin
            timer_mode_ctrl_reg    <= `TMOC_MODE_RESET;
            count_clock_select_reg <= `TMOC_CLK_RESET;
            timer_output_ctrl_reg  <= `TMOC_OUT_RESET;
            compare_register_reg   <= 16'h0000;
        end else begin
            if (wr_mode)
                timer_mode_ctrl_reg <= mode_next & 8'h0F;
            // Set beats clear so a wrap on the write cycle is kept
            if (wrap)
                timer_mode_ctrl_reg[`TMOC_MODE_OVF_BIT] <= 1'b1;
            if (wr_clk)
                count_clock_select_reg <= clk_next;
            // Set/reset bits never stored, they read back zero
            if (wr_out)
                timer_output_ctrl_reg <= out_next & 8'h07;
            if (wr_cmp)
                compare_register_reg <= cpu_wdata;
        end
    end

    // Count register, capture and output flip-flop
    always @(posedge mclk) begin
        if (!reset_n) begin
            count_register_reg   <= 16'h0000;
            capture_register_reg <= 16'h0000;
            output_flipflop_reg  <= 1'b0;
            match_irq_reg        <= 1'b0;
        end else begin
            match_irq_reg <= match;
            // Direct set/reset from a write, set takes priority
            if (wr_out && out_next[`TMOC_OUT_SET_BIT])
                output_flipflop_reg <= 1'b1;
            else if (wr_out && out_next[`TMOC_OUT_RST_BIT])
                output_flipflop_reg <= 1'b0;
            // Non-PWM running modes only; stop and PWM leave it alone
            else if (state != ST_STOP && state != ST_PWM &&
                     (match_rise || (edge_tog && input_edge)))
                output_flipflop_reg <= ~output_flipflop_reg;
            // Capture held off while the CPU reads it
            if (running && input_edge && !rd_cap)
                capture_register_reg <= count_register_reg;
            case (state)
                ST_STOP:
                    count_register_reg <= 16'h0000;
                ST_EDGE: begin
                    // Edge clear beats a tick in the same cycle
                    if (input_edge)
                        count_register_reg <= 16'h0000;
                    else if (count_tick)
                        count_register_reg <= count_register_reg + 16'h0001;
                end
                ST_MATCH: begin
                    // Clear on match; all-ones compare still wraps
                    if (count_tick && match)
                        count_register_reg <= 16'h0000;
                    else if (count_tick)
                        count_register_reg <= count_register_reg + 16'h0001;
                end
                default: begin
                    if (count_tick)
                        count_register_reg <= count_register_reg + 16'h0001;
                end
            endcase
        end
    end

    // PWM uses upper 14 bits of the compare value
    // Phase restarts whenever PWM mode is left
    tmoc_pwm #(.WIDTH(14)) tmoc_pwm_i (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .enable      (state == ST_PWM),
        .tick        (count_tick),
        .duty        (compare_register_reg[15:2]),
        .active_high (~timer_output_ctrl_reg[`TMOC_OUT_LVL_BIT]),
        .pwm_out     (pwm_wave)
    );

    // Output path: PWM or flip-flop (passed only with the invert bit set), gated by enable
    // Outside PWM the pin shows the flip-flop only with inversion on
    wire ff_view = timer_output_ctrl_reg[`TMOC_OUT_INV_BIT] ? output_flipflop_reg : 1'b0;
    assign timer_output_pin = timer_output_ctrl_reg[`TMOC_OUT_OE_BIT] &
                              ((state == ST_PWM) ? pwm_wave : ff_view);
    assign programmable_clock_pin = count_clock_select_reg[`TMOC_CLK_CLOCK_OUT_ENABLE_BIT] &
                                    clock_out_src;
    assign compare_match_irq    = match_irq_reg;
    assign count_register_value = count_register_reg;

    // Registered read data
    // Byte registers zero-extend; compare, count and capture read whole
    always @(posedge mclk) begin
        if (!reset_n)
            cpu_rdata <= 16'h0000;
        else if (cpu_rd) begin
            case (cpu_addr)
                `TMOC_MODE_ADDR: cpu_rdata <= {8'h00, timer_mode_ctrl_reg};
                `TMOC_CLK_ADDR:  cpu_rdata <= {8'h00, count_clock_select_reg};
                `TMOC_OUT_ADDR:  cpu_rdata <= {8'h00, timer_output_ctrl_reg};
                `TMOC_CMP_ADDR:  cpu_rdata <= compare_register_reg;
                `TMOC_CNT_ADDR:  cpu_rdata <= count_register_reg;
                `TMOC_CAP_ADDR:  cpu_rdata <= capture_register_reg;
                default:         cpu_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// ### tb/tmoc_monitor.sv
// Port checker of the timer mode and output control block
module tmoc_monitor (
    // Clock and reset
    input logic        mclk,
    input logic        reset_n,
    // CPU register port
    input logic [15:0] cpu_addr,
    input logic        cpu_wr,
    input logic        cpu_rd,
    input logic        cpu_bit_op,
    input logic [7:0]  cpu_bit_mask,
    input logic [15:0] cpu_wdata,
    input logic [15:0] cpu_rdata,
    // Timer events
    input logic        count_tick,
    input logic        input_edge,
    input logic        clock_out_src,
    // Pins and requests
    input logic        timer_output_pin,
    input logic        programmable_clock_pin,
    input logic        compare_match_irq,
    input logic [15:0] count_register_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]  mode_reg;  // Mirror of mode field bits 3 to 1
    logic [15:0] cmp_reg;   // Mirror of compare value
    logic        clock_out_enable_reg;  // Mirror of clock-out enable
    wire  [7:0]  lanes  = cpu_bit_op ? cpu_bit_mask : 8'hFF;
    wire         wr_mode = cpu_wr && cpu_addr == 16'hFF48;
    wire         run    = mode_reg != 3'h0;
    wire  [15:0] cnt    = count_register_value;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Mirrors follow writes; bit writes touch only masked lanes
    always @(posedge mclk) begin
        if (!reset_n) begin
            mode_reg <= 3'h0;
            cmp_reg  <= 16'h0000;
            clock_out_enable_reg <= 1'b0;
        end else if (wr_mode) begin
            mode_reg <= (mode_reg & ~lanes[3:1]) | (cpu_wdata[3:1] & lanes[3:1]);
        end else if (cpu_wr && cpu_addr == 16'hFF10) begin
            cmp_reg <= cpu_wdata;
        end else if (cpu_wr && cpu_addr == 16'hFF40 && lanes[7]) begin
            clock_out_enable_reg <= cpu_wdata[7];
        end
    end
    clk_gate_a: assert property (programmable_clock_pin == (clock_out_src && clock_out_enable_reg))
        else $error("clock pin not gated by enable");
    stop_clear_a: assert property (!run |=> cnt == 16'h0000)
        else $error("stopped count not zero");
    free_inc_a: assert property (run && mode_reg[2:1] == 2'b01 && count_tick |=> cnt == $past(cnt) + 16'h0001)
        else $error("free count did not step");
    free_hold_a: assert property (run && mode_reg[2:1] == 2'b01 && !count_tick |=> $stable(cnt))
        else $error("count moved without tick");
    edge_clear_a: assert property (run && mode_reg[2:1] == 2'b10 && input_edge |=> cnt == 16'h0000)
        else $error("edge did not clear count");
    match_clear_a: assert property (run && mode_reg[2:1] == 2'b11 && count_tick && cnt == cmp_reg
        |=> cnt == 16'h0000)
        else $error("match did not clear count");
    irq_match_a: assert property (run && cnt == cmp_reg |=> compare_match_irq)
        else $error("match request missing");
    irq_stop_a: assert property (mode_reg == 3'h0 |=> !compare_match_irq)
        else $error("request while stopped");
    out_read_a: assert property (cpu_rd && cpu_addr == 16'hFF4E |=> cpu_rdata[15:3] == 13'h0000)
        else $error("output control upper bits not zero");
    // Main scenarios seen at least once
    cover property (run && mode_reg[2:1] == 2'b01 && count_tick);
    cover property (compare_match_irq);
    cover property (programmable_clock_pin);
    cover property (mode_reg == 3'h1 && timer_output_pin);
endmodule
bind tmoc_top tmoc_monitor tmoc_monitor_i (.mclk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd,
    .cpu_bit_op, .cpu_bit_mask, .cpu_wdata, .cpu_rdata, .count_tick, .input_edge, .clock_out_src,
    .timer_output_pin, .programmable_clock_pin, .compare_match_irq, .count_register_value);

// ### tb/tmoc_top_tb_top.sv
// Directed register-level testbench of the timer mode and output control
module tmoc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, reset_n = 0, cpu_wr = 0, cpu_rd = 0, cpu_bit_op = 0;
    logic        count_tick = 0, input_edge = 0, clock_out_src = 0;
    logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
    logic [7:0]  cpu_bit_mask = 8'h00;
    wire  [15:0] cpu_rdata, count_register_value;
    wire         timer_output_pin, programmable_clock_pin, compare_match_irq;
    int          errors = 0, checked = 0;
    tmoc_top tmoc_top_i (.mclk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_bit_op, .cpu_bit_mask,
        .cpu_wdata, .cpu_rdata, .count_tick, .input_edge, .clock_out_src, .timer_output_pin,
        .programmable_clock_pin, .compare_match_irq, .count_register_value);
    // Clock and a free-toggling source for the clock-out pin
    always #2 mclk = ~mclk;
    always @(posedge mclk) clock_out_src <= ~clock_out_src;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One write strobe; a nonzero mask makes it a bit write
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] m = 8'h00);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_bit_mask <= m;
        cpu_bit_op <= m != 8'h00;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask
    // Read strobe; data settles one cycle later
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        #1 chk(cpu_rdata, exp);
    endtask
    task automatic tick(input int n);
        @(posedge mclk);
        count_tick <= 1'b1;
        repeat (n) @(posedge mclk);
        count_tick <= 1'b0;
    endtask
    task automatic pulse;
        @(posedge mclk);
        input_edge <= 1'b1;
        @(posedge mclk);
        input_edge <= 1'b0;
    endtask
    task automatic close_out;
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog sized above the long wrap run
    initial begin
        #300000;
        errors++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rdc(16'hFF48, 16'h0000);
        rdc(16'hFF4E, 16'h0000);
        chk(programmable_clock_pin, 16'h0000);
        // Set and reset lanes act once and read back as zero
        wr(16'hFF4E, 16'h0037);
        #1 chk(timer_output_pin, 16'h0001);
        rdc(16'hFF4E, 16'h0007);
        wr(16'hFF4E, 16'h0015);
        #1 chk(timer_output_pin, 16'h0000);
        wr(16'hFF40, 16'h0080, 8'h80);
        rdc(16'hFF40, 16'h0080);
        chk(programmable_clock_pin, clock_out_src);
        // Free run up to the compare value
        wr(16'hFF10, 16'h0005);
        wr(16'hFF48, 16'h0004);
        tick(5);
        #1 chk(count_register_value, 16'h0005);
        @(posedge mclk);
        #1 chk(compare_match_irq, 16'h0001);
        chk(timer_output_pin, 16'h0001);
        rdc(16'hFF12, 16'h0005);
        wr(16'hFF48, 16'h0000);
        @(posedge mclk);
        #1 chk(count_register_value, 16'h0000);
        // Input edge toggles only with the low mode bit set
        wr(16'hFF48, 16'h0006);
        pulse;
        repeat (2) @(posedge mclk);
        #1 chk(timer_output_pin, 16'h0000);
        wr(16'hFF48, 16'h0000);
        wr(16'hFF48, 16'h0004);
        pulse;
        repeat (2) @(posedge mclk);
        #1 chk(timer_output_pin, 16'h0000);
        wr(16'hFF48, 16'h0000);
        wr(16'hFF48, 16'h0008);
        tick(2);
        #1 chk(count_register_value, 16'h0002);
        pulse;
        #1 chk(count_register_value, 16'h0000);
        wr(16'hFF48, 16'h0000);
        wr(16'hFF10, 16'h0003);
        wr(16'hFF48, 16'h000C);
        tick(4);
        #1 chk(count_register_value, 16'h0000);
        // Clear on match at all ones still flags the wrap
        wr(16'hFF48, 16'h0000);
        wr(16'hFF10, 16'hFFFF);
        wr(16'hFF48, 16'h000C);
        tick(65536);
        #1 chk(count_register_value, 16'h0000);
        rdc(16'hFF48, 16'h000D);
        wr(16'hFF48, 16'h0000, 8'h01);
        rdc(16'hFF48, 16'h000C);
        for (int m = 0; m < 8; m++) begin
            wr(16'hFF48, 16'h0000);
            wr(16'hFF48, 16'(m << 1));
            rdc(16'hFF48, 16'(m << 1));
        end
        // PWM: mode first, then duty; level bit picks the active level
        wr(16'hFF48, 16'h0000);
        wr(16'hFF4E, 16'h0001);
        wr(16'hFF48, 16'h0002);
        wr(16'hFF10, 16'h0008);
        #1 chk(timer_output_pin, 16'h0001);
        tick(2);
        @(posedge mclk);
        #1 chk(timer_output_pin, 16'h0000);
        wr(16'hFF48, 16'h0000);
        wr(16'hFF4E, 16'h0003);
        wr(16'hFF48, 16'h0002);
        wr(16'hFF10, 16'h0008);
        #1 chk(timer_output_pin, 16'h0000);
        wr(16'hFF48, 16'h0000);
        close_out;
    end
endmodule
